// File: rtl/compare_control_pkg.sv
package compare_control_pkg;

  // ----------------------------------------------------------------
  // Bus and widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = 4;
  localparam int unsigned SRC_COUNT = 32;
  localparam int unsigned HALF_W = 16;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CONTROL2 = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COMPARE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_TIMER = 8'h18;

  // ----------------------------------------------------------------
  // Reset values and field layouts
  // ----------------------------------------------------------------
  localparam logic [15:0] CONTROL2_RESET = 16'h000c;
  localparam logic [31:0] PERIOD_RESET = 32'h0000ffff;
  localparam logic [31:0] HALF_MASK = 32'h0000ffff;
  localparam logic [31:0] FULL_MASK = 32'hffffffff;
  localparam int unsigned EVT_W = 3;
  localparam int unsigned EVT_FAULT = 0;
  localparam int unsigned EVT_TRIGGER = 1;
  localparam int unsigned EVT_PERIOD = 2;

  typedef struct packed {
    logic fault_recovery_mode;
    logic fault_drive_level;
    logic fault_hiz_enable;
    logic compare_output_invert;
    logic [2:0] unused;
    logic cascade_enable;
    logic trigger_or_sync_select;
    logic timer_triggered_flag;
    logic compare_pin_hiz;
    logic [4:0] sync_source_field;
  } control2_type;

  typedef struct packed {
    logic level;
    logic drive;
  } pin_type;

  typedef enum logic [1:0] {
    ST_NORMAL = 2'b01,
    ST_FAULT = 2'b10
  } fault_state_type;

endpackage : compare_control_pkg

// File: rtl/output_compare_control_two.sv
`timescale 1ns/1ps
// Notes on behaviour
// - With recovery mode 1 the fault state ends only when the fault is gone, the flag is cleared and a period starts.
// - With recovery mode 0 the fault state ends by itself when the fault is gone and a period starts.
// - In fault the drive level bit sets the pin high or low.
// - In fault the high-impedance enable releases the pin, otherwise the drive level applies.
// - The invert bit inverts the compare output.
// - Cascade joins two halves into one 32-bit timer and compare, else 16-bit.
// - Trigger select 1 starts the timer on the chosen source, 0 resets it on each source event.
// - The triggered flag is set by hardware once triggered, and while it is 0 with trigger select 1 the timer is held at zero.
// - The pin direction bit releases the pin, otherwise the channel drives it except in fault with the high-impedance enable set.
// - Bits 11 to 9 of the control register read as zero.
// - Switching the channel off emits a one-cycle trigger-out pulse.
module output_compare_control_two (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_fault,
  input wire logic [31:0] i_sync_sources,
  output logic o_compare_out,
  output logic o_compare_oe,
  output logic o_trigger_out,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] apply_strobe(input logic [31:0] old_word,
                                               input logic [31:0] new_word,
                                               input logic [3:0] strb);
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[b*8 +: 8] = new_word[b*8 +: 8];
      end
    end
    return res;
  endfunction : apply_strobe

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == compare_control_pkg::OFS_CONTROL2) || (a == compare_control_pkg::OFS_ENABLE) ||
           (a == compare_control_pkg::OFS_COMPARE) || (a == compare_control_pkg::OFS_PERIOD) ||
           (a == compare_control_pkg::OFS_STATUS) || (a == compare_control_pkg::OFS_MASK) ||
           (a == compare_control_pkg::OFS_TIMER);
  endfunction : is_mapped

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  compare_control_pkg::control2_type ctrl_q;
  compare_control_pkg::fault_state_type state_q;
  compare_control_pkg::pin_type pin_q;
  logic enable_q;
  logic enable_prev_q;
  logic [31:0] compare_q;
  logic [31:0] period_q;
  logic [31:0] timer_q;
  logic [2:0] status_q;
  logic [2:0] mask_q;
  logic trig_out_q;
  logic irq_q;
  logic fault_meta_q;
  logic fault_sync_q;
  logic [7:0] aw_addr_q;
  logic aw_full_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_full_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  logic do_write;
  logic wr_ctrl;
  logic wr_enable;
  logic wr_compare;
  logic wr_period;
  logic wr_status;
  logic wr_mask;
  logic [31:0] merged_ctrl;
  logic [31:0] merged_enable;
  logic [31:0] merged_compare;
  logic [31:0] merged_period;
  logic [31:0] merged_mask;
  logic [31:0] clear_bits;
  logic [31:0] width_mask;
  logic [31:0] rd_word;
  logic source_event;
  logic running;
  logic period_hit;
  logic trigger_set;
  logic match;
  logic [2:0] events;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  assign o_awready = !aw_full_q && !bvalid_q;
  assign o_wready = !w_full_q && !bvalid_q;
  assign o_arready = !rvalid_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_rvalid = rvalid_q;
  assign o_rresp = rresp_q;
  assign o_rdata = rdata_q;
  assign do_write = aw_full_q && w_full_q && !bvalid_q;

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_full_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
    end
    else
    begin
      if (i_awvalid && o_awready)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= i_awaddr;
      end
      if (i_wvalid && o_wready)
      begin
        w_full_q <= 1'b1;
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
      end
      if (do_write)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(aw_addr_q) ? compare_control_pkg::RESP_OKAY
                                        : compare_control_pkg::RESP_SLVERR;
      end
      else if (bvalid_q && i_bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_comb
  begin
    rd_word = 32'h00000000;
    case (i_araddr)
      compare_control_pkg::OFS_CONTROL2: rd_word = {16'h0000, ctrl_q};
      compare_control_pkg::OFS_ENABLE: rd_word = {31'h00000000, enable_q};
      compare_control_pkg::OFS_COMPARE: rd_word = compare_q;
      compare_control_pkg::OFS_PERIOD: rd_word = period_q;
      compare_control_pkg::OFS_STATUS: rd_word = {29'h00000000, status_q};
      compare_control_pkg::OFS_MASK: rd_word = {29'h00000000, mask_q};
      compare_control_pkg::OFS_TIMER: rd_word = timer_q;
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h00000000;
    end
    else if (i_arvalid && o_arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= is_mapped(i_araddr) ? compare_control_pkg::RESP_OKAY
                                     : compare_control_pkg::RESP_SLVERR;
    end
    else if (rvalid_q && i_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  assign wr_ctrl = do_write && (aw_addr_q == compare_control_pkg::OFS_CONTROL2);
  assign wr_enable = do_write && (aw_addr_q == compare_control_pkg::OFS_ENABLE);
  assign wr_compare = do_write && (aw_addr_q == compare_control_pkg::OFS_COMPARE);
  assign wr_period = do_write && (aw_addr_q == compare_control_pkg::OFS_PERIOD);
  assign wr_status = do_write && (aw_addr_q == compare_control_pkg::OFS_STATUS);
  assign wr_mask = do_write && (aw_addr_q == compare_control_pkg::OFS_MASK);
  assign merged_ctrl = apply_strobe({16'h0000, ctrl_q}, w_data_q, w_strb_q);
  assign merged_enable = apply_strobe({31'h00000000, enable_q}, w_data_q, w_strb_q);
  assign merged_compare = apply_strobe(compare_q, w_data_q, w_strb_q);
  assign merged_period = apply_strobe(period_q, w_data_q, w_strb_q);
  assign merged_mask = apply_strobe({29'h00000000, mask_q}, w_data_q, w_strb_q);
  assign clear_bits = apply_strobe(32'h00000000, w_data_q, w_strb_q);

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ctrl_q <= compare_control_pkg::CONTROL2_RESET;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_q <= merged_ctrl[15:0];
        ctrl_q.unused <= 3'h0;
      end
      else if (!enable_q)
      begin
        ctrl_q.timer_triggered_flag <= 1'b0;
      end
      if (trigger_set)
      begin
        ctrl_q.timer_triggered_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      enable_q <= 1'b0;
      compare_q <= 32'h00000000;
      period_q <= compare_control_pkg::PERIOD_RESET;
      mask_q <= 3'h0;
    end
    else
    begin
      if (wr_enable)
      begin
        enable_q <= merged_enable[0];
      end
      if (wr_compare)
      begin
        compare_q <= merged_compare;
      end
      if (wr_period)
      begin
        period_q <= merged_period;
      end
      if (wr_mask)
      begin
        mask_q <= merged_mask[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Timer, trigger and sync
  // ----------------------------------------------------------------
  // cascade width select
  assign width_mask = ctrl_q.cascade_enable ? compare_control_pkg::FULL_MASK
                                            : compare_control_pkg::HALF_MASK;
  assign source_event = i_sync_sources[ctrl_q.sync_source_field];
  assign running = enable_q && (!ctrl_q.trigger_or_sync_select || ctrl_q.timer_triggered_flag);
  assign period_hit = running && (timer_q == (period_q & width_mask));
  assign trigger_set = enable_q && ctrl_q.trigger_or_sync_select && source_event;
  assign match = running && (timer_q < (compare_q & width_mask));

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      timer_q <= 32'h00000000;
    end
    else if (!running)
    begin
      timer_q <= 32'h00000000;
    end
    else if (!ctrl_q.trigger_or_sync_select && source_event)
    begin
      timer_q <= 32'h00000000;
    end
    else if (period_hit)
    begin
      timer_q <= 32'h00000000;
    end
    else
    begin
      timer_q <= (timer_q + 32'h00000001) & width_mask;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      enable_prev_q <= 1'b0;
      trig_out_q <= 1'b0;
    end
    else
    begin
      enable_prev_q <= enable_q;
      trig_out_q <= enable_prev_q && !enable_q;
    end
  end
  assign o_trigger_out = trig_out_q;

  // ----------------------------------------------------------------
  // Fault handling
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      fault_meta_q <= 1'b0;
      fault_sync_q <= 1'b0;
    end
    else
    begin
      fault_meta_q <= i_fault;
      fault_sync_q <= fault_meta_q;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_q <= compare_control_pkg::ST_NORMAL;
    end
    else
    begin
      case (state_q)
        compare_control_pkg::ST_NORMAL:
        begin
          if (fault_sync_q)
          begin
            state_q <= compare_control_pkg::ST_FAULT;
          end
        end
        compare_control_pkg::ST_FAULT:
        begin
          if (!fault_sync_q && period_hit &&
              (!ctrl_q.fault_recovery_mode || !status_q[compare_control_pkg::EVT_FAULT]))
          begin
            state_q <= compare_control_pkg::ST_NORMAL;
          end
        end
        default: state_q <= compare_control_pkg::ST_NORMAL;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pin_q <= '0;
    end
    else if (ctrl_q.compare_pin_hiz)
    begin
      pin_q <= '0;
    end
    else if (state_q == compare_control_pkg::ST_FAULT)
    begin
      pin_q.drive <= !ctrl_q.fault_hiz_enable;
      pin_q.level <= !ctrl_q.fault_hiz_enable && ctrl_q.fault_drive_level;
    end
    else
    begin
      pin_q.drive <= 1'b1;
      pin_q.level <= match ^ ctrl_q.compare_output_invert;
    end
  end
  assign o_compare_out = pin_q.level;
  assign o_compare_oe = pin_q.drive;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign events = {period_hit, trigger_set, fault_sync_q};

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      status_q <= 3'h0;
      irq_q <= 1'b0;
    end
    else
    begin
      status_q <= (status_q & ~(wr_status ? clear_bits[2:0] : 3'h0)) | events;
      irq_q <= |(status_q & mask_q);
    end
  end
  assign o_irq = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);

  AST_FAULT_HOLD: assert property (
    state_q == compare_control_pkg::ST_FAULT && ctrl_q.fault_recovery_mode &&
    status_q[compare_control_pkg::EVT_FAULT] |=> state_q == compare_control_pkg::ST_FAULT)
    else $error("fault left while flag set");
  AST_AUTO_EXIT: assert property (
    state_q == compare_control_pkg::ST_FAULT && !ctrl_q.fault_recovery_mode &&
    !fault_sync_q && period_hit |=> state_q == compare_control_pkg::ST_NORMAL)
    else $error("fault not left automatically");
  AST_FAULT_LEVEL: assert property (
    state_q == compare_control_pkg::ST_FAULT && !ctrl_q.fault_hiz_enable &&
    !ctrl_q.compare_pin_hiz |=> o_compare_oe && o_compare_out == $past(ctrl_q.fault_drive_level))
    else $error("fault level wrong");
  AST_FAULT_HIZ: assert property (
    state_q == compare_control_pkg::ST_FAULT && ctrl_q.fault_hiz_enable |=> !o_compare_oe)
    else $error("pin driven in fault");
  AST_INVERT: assert property (
    state_q == compare_control_pkg::ST_NORMAL && !ctrl_q.compare_pin_hiz
    |=> o_compare_oe && o_compare_out == ($past(match) ^ $past(ctrl_q.compare_output_invert)))
    else $error("compare output wrong");
  AST_HALF_WIDTH: assert property (
    !ctrl_q.cascade_enable && !$past(ctrl_q.cascade_enable) |-> timer_q[31:16] == 16'h0000)
    else $error("timer exceeds 16 bits");
  AST_SYNC_RESET: assert property (
    enable_q && !ctrl_q.trigger_or_sync_select && source_event |=> timer_q == 32'h00000000)
    else $error("sync did not reset timer");
  AST_TIMER_HELD: assert property (
    ctrl_q.trigger_or_sync_select && !ctrl_q.timer_triggered_flag |=> timer_q == 32'h00000000)
    else $error("timer ran untriggered");
  AST_PIN_HIZ: assert property (
    ctrl_q.compare_pin_hiz |=> !o_compare_oe && !o_compare_out)
    else $error("pin driven while released");
  AST_RESERVED: assert property (
    ctrl_q.unused == 3'h0)
    else $error("reserved bits set");
  AST_TRIG_OUT: assert property (
    $fell(enable_q) |=> o_trigger_out ##1 !o_trigger_out)
    else $error("trigger out pulse wrong");
  AST_TRIG_SET: assert property (
    trigger_set |=> ctrl_q.timer_triggered_flag ##1 timer_q != 32'h00000000 || !running)
    else $error("trigger not taken");

  COV_FAULT_EXIT: cover property (
    state_q == compare_control_pkg::ST_FAULT ##1 state_q == compare_control_pkg::ST_NORMAL);
  COV_TRIGGER: cover property (trigger_set ##[1:20] period_hit);
  COV_DISABLE: cover property (o_trigger_out);
  COV_IRQ: cover property (o_irq && mask_q[compare_control_pkg::EVT_FAULT]);

endmodule : output_compare_control_two

// File: testbench/pin_load_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// External load on the compare pin
// ----------------------------------------------------------------
module pin_load_model (
  input wire logic i_level,
  input wire logic i_drive,
  output logic o_pin
);
  // Released pin floats to the pull-up level
  assign o_pin = i_drive ? i_level : 1'b1;
endmodule : pin_load_model

// File: testbench/output_compare_control_two_bench.sv
`timescale 1ns/1ps
module output_compare_control_two_bench;
  localparam logic [7:0] A_CTL = compare_control_pkg::OFS_CONTROL2;
  localparam logic [7:0] A_EN = compare_control_pkg::OFS_ENABLE;
  localparam logic [7:0] A_CMP = compare_control_pkg::OFS_COMPARE;
  localparam logic [7:0] A_PER = compare_control_pkg::OFS_PERIOD;
  localparam logic [7:0] A_STA = compare_control_pkg::OFS_STATUS;
  localparam logic [7:0] A_MSK = compare_control_pkg::OFS_MASK;
  localparam logic [7:0] A_TMR = compare_control_pkg::OFS_TIMER;
  logic clock, nrst, awvalid, wvalid, bready, arvalid, rready, fault;
  logic awready, wready, bvalid, arready, rvalid, pin_out, pin_oe, trig, irq, pin;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, src, rdata;
  logic [1:0] bresp, rresp;
  int n_fail, compares, cyc, n_trig;

  output_compare_control_two dut (
    .i_clock(clock), .i_nrst(nrst), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_fault(fault),
    .i_sync_sources(src), .o_compare_out(pin_out), .o_compare_oe(pin_oe),
    .o_trigger_out(trig), .o_irq(irq)
  );
  pin_load_model load (.i_level(pin_out), .i_drive(pin_oe), .o_pin(pin));

  // ----------------------------------------------------------------
  // Common tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha, hw, done;
    int t;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    t = 0;
    while (!done && t < 100)
    begin
      @(negedge clock);
      ha = awvalid && awready;
      hw = wvalid && wready;
      done = bvalid;
      r = bresp;
      @(posedge clock);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
      t++;
    end
    if (!done) n_fail++;
  endtask : axi_wr

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
  endtask : wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, done;
    int t;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    t = 0;
    while (!done && t < 100)
    begin
      @(negedge clock);
      ha = arvalid && arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (ha) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
      t++;
    end
    if (!done) n_fail++;
  endtask : axi_rd

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(name, e, d);
  endtask : rd_chk

  task automatic wait_for(ref logic s, input logic v, input string name);
    int t;
    t = 0;
    while (s !== v && t < 40)
    begin
      @(negedge clock);
      t++;
    end
    chk(name, 32'(v), 32'(s));
  endtask : wait_for

  task automatic pulse_src(input logic [31:0] v);
    @(posedge clock);
    src <= v;
    @(posedge clock);
    src <= 32'h0;
  endtask : pulse_src

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic regs_case;
    logic [31:0] d;
    logic [1:0] r;
    rd_chk("control2", A_CTL, 32'h0000000c);
    rd_chk("period", A_PER, 32'h0000ffff);
    wr(A_CTL, 32'h0000ffbf);
    rd_chk("control2", A_CTL, 32'h0000f1bf);
    wr(A_CTL, 32'h0);
    axi_wr(8'h1c, 32'h1, r);
    chk("bresp", 32'h2, 32'(r));
    axi_rd(8'h1c, d, r);
    chk("rresp", 32'h2, 32'(r));
    wr(A_TMR, 32'h1234);
    rd_chk("timer", A_TMR, 32'h0);
  endtask : regs_case

  task automatic disable_case;
    n_trig = 0;
    wr(A_EN, 32'h0);
    tick(6);
    chk("trigger_pulses", 32'h1, 32'(n_trig));
  endtask : disable_case

  task automatic invert_case;
    wr(A_PER, 32'h8);
    wr(A_CMP, 32'h20);
    wr(A_EN, 32'h1);
    wait_for(pin, 1'b1, "pin");
    wr(A_CTL, 32'h1000);
    wait_for(pin, 1'b0, "pin");
    chk("oe", 32'h1, 32'(pin_oe));
    wr(A_CTL, 32'h1020);
    tick(2);
    chk("oe", 32'h0, 32'(pin_oe));
  endtask : invert_case

  task automatic fault_case(input logic mode);
    logic [31:0] c;
    c = mode ? 32'hc000 : 32'h4000;
    wr(A_CTL, c);
    // Timer must run so that a new period can end the fault
    wr(A_EN, 32'h1);
    wr(A_CMP, 32'h0);
    wr(A_MSK, 32'h1);
    wr(A_STA, 32'h7);
    fault <= 1'b1;
    wait_for(irq, 1'b1, "irq");
    wait_for(pin, 1'b1, "pin");
    wr(A_CTL, c | 32'h2000);
    tick(2);
    chk("oe", 32'h0, 32'(pin_oe));
    wr(A_CTL, c & 32'h8000);
    wait_for(pin, 1'b0, "pin");
    chk("oe", 32'h1, 32'(pin_oe));
    wr(A_CTL, c);
    wait_for(pin, 1'b1, "pin");
    wr(A_MSK, 32'h0);
    wait_for(irq, 1'b0, "irq");
    wr(A_MSK, 32'h1);
    fault <= 1'b0;
    if (mode)
    begin
      tick(40);
      chk("pin", 32'h1, 32'(pin));
      wr(A_STA, 32'h1);
    end
    wait_for(pin, 1'b0, "pin");
    wr(A_STA, 32'h7);
    wait_for(irq, 1'b0, "irq");
    disable_case();
  endtask : fault_case

  task automatic trigger_case;
    logic [31:0] d;
    logic [1:0] r;
    wr(A_PER, 32'hffff);
    // Source 3 is another channel, never this one
    wr(A_CTL, 32'h0083);
    wr(A_EN, 32'h1);
    tick(5);
    rd_chk("timer", A_TMR, 32'h0);
    rd_chk("control2", A_CTL, 32'h0083);
    pulse_src(32'h8);
    tick(3);
    rd_chk("control2", A_CTL, 32'h00c3);
    axi_rd(A_TMR, d, r);
    chk("timer_running", 32'h1, 32'(d != 0));
    // Source deselected before the channel goes off
    wr(A_CTL, 32'h0);
    disable_case();
  endtask : trigger_case

  task automatic cascade_case;
    logic [31:0] d;
    logic [1:0] r;
    wr(A_PER, 32'h00010005);
    wr(A_EN, 32'h1);
    tick(20);
    axi_rd(A_TMR, d, r);
    chk("timer_narrow", 32'h1, 32'(d <= 5));
    wr(A_CTL, 32'h0100);
    tick(30);
    axi_rd(A_TMR, d, r);
    chk("timer_wide", 32'h1, 32'(d > 5));
    pulse_src(32'h1);
    axi_rd(A_TMR, d, r);
    chk("timer_sync", 32'h1, 32'(d < 8));
    disable_case();
  endtask : cascade_case

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(negedge clock)
  begin
    cyc++;
    if (trig === 1'b1) n_trig++;
    if (cyc == 20000)
    begin
      n_fail++;
      results();
    end
  end

  initial
  begin
    {nrst, awvalid, wvalid, bready, arvalid, rready, fault} = 7'h0;
    {awaddr, araddr, wdata, src} = 80'h0;
    {n_fail, compares, cyc, n_trig} = 128'h0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    regs_case();
    invert_case();
    fault_case(1'b0);
    fault_case(1'b1);
    trigger_case();
    cascade_case();
    results();
  end
endmodule : output_compare_control_two_bench
